/* uilf_core.sv */
// Interrupt identification and line format control with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "uilf_params.svh"
module uilf_core
   import uilf_pkg::*;
(
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst,
   // APB slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [`UILF_ADDR_W-1:0]  paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   // Interrupt source events, one-cycle pulses
   input  wire logic                     lineConditionSource,
   input  wire logic                     rxDataAvailable,
   input  wire logic                     rxTimeoutSeen,
   input  wire logic                     txHoldingEmpty,
   input  wire logic                     modemChangeSource,
   // FIFO state from the FIFO control logic
   input  wire logic                     fifoEnabled,
   input  wire logic                     fifoDeep,
   // Transmit path
   input  wire logic                     txSerialData,
   input  wire logic [7:0]               txData,
   output logic                          txLine,
   output logic                          txParityBit,
   // Receive check path
   input  wire logic                     rxCheck,
   input  wire logic [7:0]               rxData,
   input  wire logic                     rxParityBit,
   output logic                          rxParityError,
   // Line format to transmitter and receiver
   output logic      [3:0]               wordLength,
   output logic      [2:0]               stopHalfBits,
   output logic                          parityEnable,
   output logic                          breakActive,
   output logic                          divisorAccess
);
   // Register state
   logic [7:0]             lineFormatControl;
   logic [`UILF_PEND_W-1:0] pending;
   uilf_src_t              current;
   uilf_src_t              next_current;
   uilf_src_t              readSource;

   // Bus decode
   logic                   setupPhase;
   logic                   accessDone;
   logic                   hitIdent;
   logic                   hitLineCtl;
   logic                   hitPending;
   logic                   hitAny;
   logic [`UILF_PEND_W-1:0] clearMask;
   logic [`UILF_PEND_W-1:0] next_pending;

   // Identification view
   logic [3:0]             sourceCode;
   logic [7:0]             identValue;

   // Parity helpers
   uilf_parity_t           parityMode;
   logic                   txParityCalc;
   logic                   rxParityCalc;

   // Transfer phases and address decode
   assign setupPhase = psel & ~penable;
   assign accessDone = psel & penable & pready;
   assign hitIdent   = (paddr == `UILF_OFS_IDENT);
   assign hitLineCtl = (paddr == `UILF_OFS_LINECTL);
   assign hitPending = (paddr == `UILF_OFS_PENDING);
   assign hitAny     = hitIdent | hitLineCtl | hitPending;

   // Read data is captured in setup, so the access phase needs no wait
   assign pready  = 1'b1;
   // Unmapped offsets answer with an error in the access phase
   assign pslverr = psel & penable & ~hitAny;

   // Code of the latched source
   always_comb begin
      case (current)
         SRC_LINE:      sourceCode = `UILF_CODE_LINE;
         SRC_RXDATA:    sourceCode = `UILF_CODE_RXDATA;
         SRC_RXTIMEOUT: sourceCode = `UILF_CODE_RXTO;
         SRC_TXEMPTY:   sourceCode = `UILF_CODE_TXEMPTY;
         SRC_MODEM:     sourceCode = `UILF_CODE_MODEM;
         SRC_NONE:      sourceCode = `UILF_CODE_NONE;
         default:       sourceCode = `UILF_CODE_NONE;
      endcase
   end

   // Identification byte: FIFO flags, depth flag, unused zero, code
   always_comb begin
      identValue = `UILF_IDENT_RST;
      identValue[`UILF_ID_FIFO_HI] = fifoEnabled;
      identValue[`UILF_ID_FIFO_LO] = fifoEnabled;
      identValue[`UILF_ID_DEEP]    = fifoDeep;
      identValue[`UILF_ID_UNUSED]  = 1'b0;
      identValue[3:0]              = sourceCode;
   end

   // Read data register, loaded in the setup cycle of a read
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (setupPhase && !pwrite) begin
         if (hitIdent) begin
            prdata <= {24'h00_0000, identValue};
         end else if (hitLineCtl) begin
            prdata <= {24'h00_0000, lineFormatControl};
         end else if (hitPending) begin
            prdata <= {27'h000_0000, pending};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // Source seen by the read now in progress
   always_ff @(posedge clk) begin
      if (rst) begin
         readSource <= SRC_NONE;
      end else if (setupPhase) begin
         readSource <= (hitIdent && !pwrite) ? current : SRC_NONE;
      end
   end

   // Clear mask: only the source returned by this read
   always_comb begin
      clearMask = '0;
      // A write, or a read of another register, clears nothing
      if (accessDone && !pwrite && hitIdent) begin
         case (readSource)
            SRC_LINE:      clearMask[`UILF_PEND_LINE]    = 1'b1;
            SRC_RXDATA:    clearMask[`UILF_PEND_RXDATA]  = 1'b1;
            SRC_RXTIMEOUT: clearMask[`UILF_PEND_RXTO]    = 1'b1;
            SRC_TXEMPTY:   clearMask[`UILF_PEND_TXEMPTY] = 1'b1;
            SRC_MODEM:     clearMask[`UILF_PEND_MODEM]   = 1'b1;
            SRC_NONE:      clearMask = '0;
            default:       clearMask = '0;
         endcase
      end
   end

   // Sticky pending flags; a new event wins over the read that clears it
   always_comb begin
      next_pending = pending & ~clearMask;
      // Each pulse sets its flag even in the cycle of a clearing read
      if (lineConditionSource) begin
         next_pending[`UILF_PEND_LINE] = 1'b1;
      end
      if (rxDataAvailable) begin
         next_pending[`UILF_PEND_RXDATA] = 1'b1;
      end
      if (rxTimeoutSeen) begin
         next_pending[`UILF_PEND_RXTO] = 1'b1;
      end
      if (txHoldingEmpty) begin
         next_pending[`UILF_PEND_TXEMPTY] = 1'b1;
      end
      if (modemChangeSource) begin
         next_pending[`UILF_PEND_MODEM] = 1'b1;
      end
   end

   // Pending flag register
   always_ff @(posedge clk) begin
      if (rst) begin
         pending <= '0;
      end else begin
         pending <= next_pending;
      end
   end

   // Latched source: kept until its read, then the next highest is taken
   always_comb begin
      next_current = current;
      case (current)
         SRC_NONE: begin
            // Highest pending source; timeout ranks above data ready
            if (pending[`UILF_PEND_LINE]) begin
               next_current = SRC_LINE;
            end else if (pending[`UILF_PEND_RXTO]) begin
               next_current = SRC_RXTIMEOUT;
            end else if (pending[`UILF_PEND_RXDATA]) begin
               next_current = SRC_RXDATA;
            end else if (pending[`UILF_PEND_TXEMPTY]) begin
               next_current = SRC_TXEMPTY;
            end else if (pending[`UILF_PEND_MODEM]) begin
               next_current = SRC_MODEM;
            end
         end
         SRC_LINE, SRC_RXDATA, SRC_RXTIMEOUT, SRC_TXEMPTY, SRC_MODEM: begin
            // Hold the reported source until the read that services it
            if (accessDone && !pwrite && hitIdent && readSource == current) begin
               next_current = SRC_NONE;
            end
         end
         default: next_current = SRC_NONE;
      endcase
   end

   // Latched source register
   always_ff @(posedge clk) begin
      if (rst) begin
         current <= SRC_NONE;
      end else begin
         current <= next_current;
      end
   end

   // Line format control register, written at the end of the access phase
   always_ff @(posedge clk) begin
      if (rst) begin
         lineFormatControl <= `UILF_LINECTL_RST;
      end else if (accessDone && pwrite && hitLineCtl) begin
         lineFormatControl <= pwdata[7:0];
      end
   end

   // Parity mode from force and even bits
   assign parityMode = uilf_parity_t'({lineFormatControl[`UILF_LC_FORCE],
                                       lineFormatControl[`UILF_LC_EVEN]});

   // Transmit parity generator
   uilf_parity_unit txParity (
      .dataBits   (txData),
      .wordSel    (lineFormatControl[`UILF_LC_WLEN_HI:`UILF_LC_WLEN_LO]),
      .parityMode (parityMode),
      .parityBit  (txParityCalc)
   );

   // Receive parity checker
   uilf_parity_unit rxParity (
      .dataBits   (rxData),
      .wordSel    (lineFormatControl[`UILF_LC_WLEN_HI:`UILF_LC_WLEN_LO]),
      .parityMode (parityMode),
      .parityBit  (rxParityCalc)
   );

   // Transmit parity bit, zero when parity is off
   always_ff @(posedge clk) begin
      if (rst) begin
         txParityBit <= 1'b0;
      end else begin
         txParityBit <= lineFormatControl[`UILF_LC_PAREN] & txParityCalc;
      end
   end

   // Receive parity error pulse, only when parity is enabled
   always_ff @(posedge clk) begin
      if (rst) begin
         rxParityError <= 1'b0;
      end else begin
         rxParityError <= rxCheck & lineFormatControl[`UILF_LC_PAREN]
                          & (rxParityBit != rxParityCalc);
      end
   end

   // Transmit line, forced low during break
   always_ff @(posedge clk) begin
      if (rst) begin
         txLine <= 1'b1;
      end else begin
         txLine <= txSerialData & ~lineFormatControl[`UILF_LC_BREAK];
      end
   end

   // Word length in data bits
   always_ff @(posedge clk) begin
      if (rst) begin
         wordLength <= 4'h5;
      end else begin
         case (lineFormatControl[`UILF_LC_WLEN_HI:`UILF_LC_WLEN_LO])
            `UILF_WLEN_5: wordLength <= 4'h5;
            `UILF_WLEN_6: wordLength <= 4'h6;
            `UILF_WLEN_7: wordLength <= 4'h7;
            `UILF_WLEN_8: wordLength <= 4'h8;
            default:      wordLength <= 4'h5;
         endcase
      end
   end

   // Stop length in half bit times
   always_ff @(posedge clk) begin
      if (rst) begin
         stopHalfBits <= `UILF_STOP_ONE;
      end else if (!lineFormatControl[`UILF_LC_STOP]) begin
         stopHalfBits <= `UILF_STOP_ONE;
      end else if (lineFormatControl[`UILF_LC_WLEN_HI:`UILF_LC_WLEN_LO] == `UILF_WLEN_5) begin
         stopHalfBits <= `UILF_STOP_ONEHALF;
      end else begin
         stopHalfBits <= `UILF_STOP_TWO;
      end
   end

   // Plain control flags to transmitter, receiver and register decoder
   always_ff @(posedge clk) begin
      if (rst) begin
         parityEnable  <= 1'b0;
         breakActive   <= 1'b0;
         divisorAccess <= 1'b0;
      end else begin
         parityEnable  <= lineFormatControl[`UILF_LC_PAREN];
         breakActive   <= lineFormatControl[`UILF_LC_BREAK];
         divisorAccess <= lineFormatControl[`UILF_LC_DIVLATCH];
      end
   end
endmodule
`default_nettype wire

/* uilf_params.svh */
// Register offsets, field positions, reset values and codes for the UART ident/format block
`ifndef UILF_PARAMS_SVH
`define UILF_PARAMS_SVH

// APB address width and register byte offsets
`define UILF_ADDR_W        12
`define UILF_OFS_IDENT     12'h000
`define UILF_OFS_LINECTL   12'h004
`define UILF_OFS_PENDING   12'h008

// Reset values
`define UILF_IDENT_RST     8'h01
`define UILF_LINECTL_RST   8'h00

// Interrupt identification field positions
`define UILF_ID_FIFO_HI    7
`define UILF_ID_FIFO_LO    6
`define UILF_ID_DEEP       5
`define UILF_ID_UNUSED     4

// Source codes in identification bits [3:0]
`define UILF_CODE_LINE     4'h6
`define UILF_CODE_RXDATA   4'h4
`define UILF_CODE_RXTO     4'hc
`define UILF_CODE_TXEMPTY  4'h2
`define UILF_CODE_MODEM    4'h0
`define UILF_CODE_NONE     4'h1

// Pending vector bit positions
`define UILF_PEND_LINE     0
`define UILF_PEND_RXDATA   1
`define UILF_PEND_RXTO     2
`define UILF_PEND_TXEMPTY  3
`define UILF_PEND_MODEM    4
`define UILF_PEND_W        5

// Line format control field positions
`define UILF_LC_DIVLATCH   7
`define UILF_LC_BREAK      6
`define UILF_LC_FORCE      5
`define UILF_LC_EVEN       4
`define UILF_LC_PAREN      3
`define UILF_LC_STOP       2
`define UILF_LC_WLEN_HI    1
`define UILF_LC_WLEN_LO    0

// Word length selections and stop lengths in half bit times
`define UILF_WLEN_5        2'b00
`define UILF_WLEN_6        2'b01
`define UILF_WLEN_7        2'b10
`define UILF_WLEN_8        2'b11
`define UILF_STOP_ONE      3'd2
`define UILF_STOP_ONEHALF  3'd3
`define UILF_STOP_TWO      3'd4

`endif

/* uilf_pkg.sv */
// Types shared by the UART ident/format block
package uilf_pkg;
   // Latched interrupt source, one-hot
   typedef enum logic [5:0] {
      SRC_NONE      = 6'b000001,
      SRC_LINE      = 6'b000010,
      SRC_RXDATA    = 6'b000100,
      SRC_RXTIMEOUT = 6'b001000,
      SRC_TXEMPTY   = 6'b010000,
      SRC_MODEM     = 6'b100000
   } uilf_src_t;

   // Parity mode as {force, even}
   typedef enum logic [1:0] {
      PAR_ODD  = 2'b00,
      PAR_EVEN = 2'b01,
      PAR_ONE  = 2'b10,
      PAR_ZERO = 2'b11
   } uilf_parity_t;
endpackage

/* uilf_parity_unit.sv */
// Parity bit generator for a character of programmable length
`timescale 1ns/1ps
`default_nettype none
`include "uilf_params.svh"
module uilf_parity_unit
   import uilf_pkg::*;
(
   // Character and format
   input  wire logic [7:0]   dataBits,
   input  wire logic [1:0]   wordSel,
   input  wire uilf_parity_t parityMode,
   // Resulting parity bit
   output logic              parityBit
);
   logic [7:0] mask;
   logic       onesOdd;

   // Mask off bits beyond the selected word length
   always_comb begin
      case (wordSel)
         `UILF_WLEN_5: mask = 8'h1f;
         `UILF_WLEN_6: mask = 8'h3f;
         `UILF_WLEN_7: mask = 8'h7f;
         default:      mask = 8'hff;
      endcase
   end

   assign onesOdd = ^(dataBits & mask);

   // Odd, even or forced parity bit
   always_comb begin
      case (parityMode)
         PAR_ODD:  parityBit = ~onesOdd;
         PAR_EVEN: parityBit = onesOdd;
         PAR_ONE:  parityBit = 1'b1;
         PAR_ZERO: parityBit = 1'b0;
         default:  parityBit = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

/* uilf_core_properties.sv */
// Concurrent checks on the ident/format block ports
`timescale 1ns/1ps
`default_nettype none
`include "uilf_params.svh"
module uilf_core_properties
   import uilf_pkg::*;
(
   // Clock, reset and bus
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   // FIFO state and serial paths
   input wire logic        fifoEnabled,
   input wire logic        fifoDeep,
   input wire logic        txSerialData,
   input wire logic        txLine,
   input wire logic        txParityBit,
   input wire logic        rxCheck,
   input wire logic        rxParityError,
   // Line format outputs
   input wire logic [3:0]  wordLength,
   input wire logic [2:0]  stopHalfBits,
   input wire logic        parityEnable,
   input wire logic        breakActive
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Access phase of an ident read
   logic identAcc;
   assign identAcc = psel && penable && !pwrite && paddr == `UILF_OFS_IDENT;

   ident_fifo_bits_a: assert property (identAcc |-> prdata[7:6] == {2{$past(fifoEnabled)}})
      else $error("ident fifo bits wrong");
   ident_deep_bit_a: assert property (identAcc |-> prdata[5] == $past(fifoDeep))
      else $error("ident depth bit wrong");
   ident_code_legal_a: assert property (identAcc |-> !prdata[4] &&
      prdata[3:0] inside {4'h6, 4'hc, 4'h4, 4'h2, 4'h0, 4'h1}) else $error("ident code illegal");
   break_low_a: assert property (breakActive |-> !txLine)
      else $error("tx not held low in break");
   tx_follow_a: assert property (!breakActive && !$past(rst) |->
      txLine == $past(txSerialData)) else $error("tx line does not follow data");
   stop_len_a: assert property (stopHalfBits inside {3'd2, 3'd3, 3'd4} &&
      (stopHalfBits != 3'd3 || wordLength == 4'd5)) else $error("stop length wrong");
   word_len_a: assert property (wordLength inside {4'd5, 4'd6, 4'd7, 4'd8})
      else $error("word length out of range");
   parity_off_a: assert property (!parityEnable |-> !txParityBit && !rxParityError)
      else $error("parity active while disabled");
   rx_err_cause_a: assert property (rxParityError |-> $past(rxCheck) && parityEnable)
      else $error("parity error without check");
endmodule
bind uilf_core uilf_core_properties uilf_core_properties_inst (.clk, .rst, .psel, .penable,
   .pwrite, .paddr, .prdata, .fifoEnabled, .fifoDeep, .txSerialData, .txLine, .txParityBit,
   .rxCheck, .rxParityError, .wordLength, .stopHalfBits, .parityEnable, .breakActive);
`default_nettype wire

/* uilf_host_model.sv */
// Host processor model acting as register bus master
`timescale 1ns/1ps
`default_nettype none
module uilf_host_model
   import uilf_pkg::*;
(
   // Clock
   input  wire logic        clk,
   // Bus master side
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   // Idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end

   // One transfer; holds the request until ready is sampled high, for at most 64 access cycles
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e, output logic ok);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!pready && n < 64);
      r = prdata;
      e = pslverr;
      ok = pready;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d; // Released data no longer shows the last value
      @(posedge clk);
   endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the ident/format block
`timescale 1ns/1ps
`default_nettype none
`include "uilf_params.svh"
module tb_top;
   import uilf_pkg::*;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, er, ok;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [4:0]  ev;
   logic        fifoEnabled, fifoDeep, txSerialData, rxCheck, rxParityBit;
   logic [7:0]  txData, rxData, c;
   logic        txLine, txParityBit, rxParityError, parityEnable, breakActive, divisorAccess;
   logic [3:0]  wordLength;
   logic [2:0]  stopHalfBits;
   int          failures, checks_done, pend, held;
   logic [3:0]  codes [6] = '{4'h6, 4'h4, 4'hc, 4'h2, 4'h0, 4'h1};

   uilf_host_model host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr);
   uilf_core uilf_core_inst (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .lineConditionSource(ev[0]), .rxDataAvailable(ev[1]),
      .rxTimeoutSeen(ev[2]), .txHoldingEmpty(ev[3]), .modemChangeSource(ev[4]), .fifoEnabled,
      .fifoDeep, .txSerialData, .txData, .txLine, .txParityBit, .rxCheck, .rxData,
      .rxParityBit, .rxParityError, .wordLength, .stopHalfBits, .parityEnable, .breakActive,
      .divisorAccess);

   // Clock at 40 MHz
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Xorshift step
   function void advance();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
   endfunction
   // Expected parity for a character under a line format
   function automatic logic par(logic [7:0] d, logic [7:0] f);
      logic [7:0] m;
      m = d & (8'hff >> (2'd3 - f[1:0]));
      if (!f[3]) return 1'b0;
      if (f[5]) return ~f[4];
      return f[4] ? ^m : ~^m;
   endfunction
   // Highest pending source: line, timeout, data, empty, modem
   function automatic int top(int p);
      foreach (codes[i]) if (p[i == 1 ? 2 : i == 2 ? 1 : i]) return i == 1 ? 2 : i == 2 ? 1 : i;
      return 5;
   endfunction
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task complete_run;
      $display("checks=%0d failures=%0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      host.xfer(w, a, d, rd, er, ok);
      if (!ok) begin
         failures++;
         complete_run;
      end
   endtask
   // Let the block latch, then mirror its choice in the model
   task settle;
      repeat (4) @(posedge clk);
      if (held == 5) held = top(pend);
   endtask
   task pulse(input logic [4:0] m);
      ev <= m;
      @(posedge clk);
      ev <= 5'h0;
      pend |= m;
      settle;
   endtask
   task read_id;
      logic [1:0] f;
      advance();
      f = seed[1:0];
      fifoEnabled <= f[0];
      fifoDeep <= f[1];
      settle;
      bus(1'b0, `UILF_OFS_IDENT, 32'h0);
      check(rd, {24'h0, {2{f[0]}}, f[1], 1'b0, codes[held]});
      if (held != 5) pend &= ~(1 << held);
      held = 5;
      bus(1'b0, `UILF_OFS_PENDING, 32'h0);
      check(rd, pend);
   endtask

   // Main sequence
   initial begin
      {rst, ev, fifoEnabled, fifoDeep, txSerialData, rxCheck, rxParityBit} = '1;
      {ev, fifoEnabled, fifoDeep, txSerialData, rxCheck, rxParityBit, txData, rxData} = '0;
      seed = 32'he6c8;
      failures = 0;
      checks_done = 0;
      pend = 0;
      held = 5;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check({wordLength, 1'b0, stopHalfBits}, 32'h52);
      check({parityEnable, breakActive, divisorAccess}, 32'h0);
      bus(1'b0, `UILF_OFS_LINECTL, 32'h0);
      check(rd, 32'h0);
      read_id; // Idle code after reset
      bus(1'b1, `UILF_OFS_IDENT, 32'h0f);
      read_id; // Write to ident is ignored
      pulse(5'h1f);
      repeat (6) read_id; // All sources in priority order
      pulse(5'h08);
      pulse(5'h01);
      repeat (3) read_id; // Empty stays reported before line status
      bus(1'b0, 12'h00c, 32'h0);
      check({er, rd[30:0]}, 32'h8000_0000);
      for (int i = 0; i < 48; i++) begin
         advance();
         c = seed[7:0];
         bus(1'b1, `UILF_OFS_LINECTL, {24'h0, c});
         bus(1'b1, 12'h010, 32'h0);
         bus(1'b0, `UILF_OFS_LINECTL, 32'h0);
         check(rd, {24'h0, c});
         check(divisorAccess, c[7]);
         check(wordLength, 5 + c[1:0]);
         check(stopHalfBits, !c[2] ? 2 : c[1:0] == 2'b00 ? 3 : 4);
         check(parityEnable, c[3]);
         check(breakActive, c[6]);
         advance();
         txData <= seed[7:0];
         rxData <= seed[15:8];
         rxParityBit <= seed[16];
         txSerialData <= seed[17];
         rxCheck <= 1'b1;
         @(posedge clk);
         rxCheck <= 1'b0;
         @(posedge clk);
         check(rxParityError, c[3] && (seed[16] != par(seed[15:8], c)));
         check(txParityBit, par(seed[7:0], c));
         check(txLine, seed[17] & ~c[6]);
      end
      complete_run;
   end
endmodule
`default_nettype wire
